// *** rtl/hbc_defines.svh ***
// timing and reset constants for the h-bridge control logic
`ifndef HBC_DEFINES_SVH
`define HBC_DEFINES_SVH
`define HBC_CLK_PERIOD_NS 50
`define HBC_OC_DEGLITCH_NS 4200
`define HBC_OC_DEGLITCH_CYC ((`HBC_OC_DEGLITCH_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS)
`define HBC_RETRY_NS 1700000
`define HBC_RETRY_CYC (`HBC_RETRY_NS / `HBC_CLK_PERIOD_NS)
`define HBC_SLEEP_MIN_NS 1000000
`define HBC_SLEEP_CYC ((`HBC_SLEEP_MIN_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS)
`define HBC_WAKE_CYC 16
`define HBC_TIMER_W 16
`define HBC_PIN_COUNT 10
`define HBC_OC_OFF_RESET 2'h0
`endif

// *** rtl/hbc_pkg.sv ***
// types shared by the h-bridge control logic
package hbc_pkg;
	typedef enum logic [1:0] {HBC_IF_DIRECT, HBC_IF_PHASE, HBC_IF_HALF} hbc_iface_t;
	typedef enum logic [1:0] {HBC_LEG_OFF, HBC_LEG_LOW, HBC_LEG_HIGH} hbc_leg_t;
	typedef enum logic {HBC_PWR_ACTIVE, HBC_PWR_ASLEEP} hbc_power_t;
endpackage

// *** rtl/hbc_sync.sv ***
// two-flop synchroniser for asynchronous pin inputs
module hbc_sync #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] pinOut
);
	initial
	begin
		if (W < 1)
			$error("hbc_sync: width must be at least one");
	end

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic stage1;
			logic stage2;
			// each bit owns its flops, so no two processes write one vector
			always_ff @(posedge core_clk)
			begin
				if (rst)
				begin
					stage1 <= 1'b0;
					stage2 <= 1'b0;
				end
				else
				begin
					stage1 <= pinIn[i];
					stage2 <= stage1;
				end
			end
			assign pinOut[i] = stage2;
		end
	endgenerate
endmodule

// *** rtl/hbc_timer.sv ***
// saturating up-counter with clear, flags when the limit is reached
module hbc_timer #(
	parameter int W = 16
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic [W-1:0] limit,
	output logic done
);
	logic [W-1:0] count;

	initial
	begin
		if (W < 2)
			$error("hbc_timer: width must be at least two");
	end

	// clear has priority so a restart never sees a stale count
	always_ff @(posedge core_clk)
	begin
		if (rst || clear)
			count <= '0;
		else if (count != limit)
			count <= count + 1'b1;
	end

	assign done = !clear && (count == limit);
endmodule

// *** rtl/hbc_control_logic.sv ***
// input decode, autosleep and protection sequencing for a two-output h-bridge
// Summary of operation
// - mode low or single supply: direct control
// - direct truth table: coast, reverse, forward, brake
// - direct coast held for interval enters sleep
// - mode high selects direction and speed gate
// - gate high: direction picks output polarity
// - gate low brakes both low sides
// - gate low past interval: sleep, outputs off
// - floating mode selects independent half-bridges
// - each half follows its own input
// - lockout disables switches, pump and logic
// - lockout source depends on supply variant
// - lockout released once supply recovers
// - deglitched overcurrent disables whole bridge
// - retry re-enables from pins, repeats if persisting
// - half mode disables only affected half
// - shared retry timer; second trip restarts both
// - overtemperature disables bridge until it clears
// - overcurrent deglitch about 4.2 microseconds
// - overcurrent retry about 1.7 milliseconds
// - autosleep after 1 to 2 milliseconds idle
`include "hbc_defines.svh"

module hbc_control_logic #(
	parameter int TW = `HBC_TIMER_W,
	parameter int RETRY_CYCLES = `HBC_RETRY_CYC,
	parameter int SLEEP_CYCLES = `HBC_SLEEP_CYC,
	parameter int WAKE_CYCLES = `HBC_WAKE_CYC,
	parameter int OC_CYCLES = `HBC_OC_DEGLITCH_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic splitVariant,
	input wire logic modeLevel,
	input wire logic modeFloating,
	input wire logic driveInputA,
	input wire logic driveInputB,
	input wire logic logicSupplyLow,
	input wire logic motorSupplyLow,
	input wire logic overcurrentA,
	input wire logic overcurrentB,
	input wire logic thermalCutoff,
	output logic highSideA,
	output logic lowSideA,
	output logic highSideB,
	output logic lowSideB,
	output logic chargePumpEnable,
	output logic lowPowerSleep,
	output logic lockoutActive,
	output logic overcurrentOffA,
	output logic overcurrentOffB,
	output logic thermalActive,
	output hbc_pkg::hbc_iface_t activeInterface
);
	import hbc_pkg::*;

	initial
	begin
		if (TW < 2 || TW > 31)
			$error("hbc_control_logic: timer width out of range");
		if (RETRY_CYCLES < 1 || RETRY_CYCLES >= (1 << TW))
			$error("hbc_control_logic: retry count does not fit the timer");
		if (SLEEP_CYCLES < 1 || SLEEP_CYCLES >= (1 << TW))
			$error("hbc_control_logic: sleep count does not fit the timer");
		if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << TW))
			$error("hbc_control_logic: wake count does not fit the timer");
		if (OC_CYCLES < 1 || OC_CYCLES >= (1 << TW))
			$error("hbc_control_logic: deglitch count does not fit the timer");
	end

	logic [`HBC_PIN_COUNT-1:0] rawPins;
	logic [`HBC_PIN_COUNT-1:0] syncPins;
	logic isSplit;
	logic modeHigh;
	logic modeFloat;
	logic inA;
	logic inB;
	logic logicLow;
	logic motorLow;
	logic [1:0] ocRaw;
	logic hot;
	logic lockout;
	hbc_iface_t iface;
	hbc_power_t powerState;
	logic sleepQualify;
	logic wakeQualify;
	logic sleepDone;
	logic wakeDone;
	logic [1:0] trip;
	logic [1:0] ocOff;
	logic [1:0] next_ocOff;
	logic retryRunning;
	logic retryDone;
	logic driveGate;
	hbc_leg_t legA;
	hbc_leg_t legB;
	hbc_leg_t next_legA;
	hbc_leg_t next_legB;

	// every pin is asynchronous to core_clk, including the variant strap
	assign rawPins = {splitVariant, modeLevel, modeFloating, driveInputA, driveInputB,
		logicSupplyLow, motorSupplyLow, overcurrentB, overcurrentA, thermalCutoff};

	hbc_sync #(
		.W(`HBC_PIN_COUNT)
	) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.pinIn(rawPins),
		.pinOut(syncPins)
	);

	assign isSplit = syncPins[9];
	assign modeHigh = syncPins[8];
	assign modeFloat = syncPins[7];
	assign inA = syncPins[6];
	assign inB = syncPins[5];
	assign logicLow = syncPins[4];
	assign motorLow = syncPins[3];
	assign ocRaw = syncPins[2:1];
	assign hot = syncPins[0];

	// motor supply may sit at zero on the split variant without tripping
	assign lockout = isSplit ? logicLow : motorLow;

	// mode is decoded live, so it may change while running
	always_comb
	begin
		if (!isSplit || (!modeFloat && !modeHigh))
			iface = HBC_IF_DIRECT;
		else if (modeFloat)
			iface = HBC_IF_HALF;
		else
			iface = HBC_IF_PHASE;
	end

	// half mode never qualifies: the controller must pull mode low first
	always_comb
	begin
		case (iface)
			HBC_IF_DIRECT:
			begin
				sleepQualify = !inA && !inB;
				wakeQualify = inA || inB;
			end
			HBC_IF_PHASE:
			begin
				sleepQualify = !inB;
				wakeQualify = inB;
			end
			HBC_IF_HALF:
			begin
				sleepQualify = 1'b0;
				wakeQualify = 1'b0;
			end
			default:
			begin
				sleepQualify = 1'b0;
				wakeQualify = 1'b0;
			end
		endcase
	end

	hbc_timer #(
		.W(TW)
	) u_sleepTimer (
		.core_clk(core_clk),
		.rst(rst),
		.clear(!sleepQualify || powerState != HBC_PWR_ACTIVE || lockout),
		.limit(TW'(SLEEP_CYCLES)),
		.done(sleepDone)
	);

	// a single low glitch restarts the wake count
	hbc_timer #(
		.W(TW)
	) u_wakeTimer (
		.core_clk(core_clk),
		.rst(rst),
		.clear(!wakeQualify || powerState != HBC_PWR_ASLEEP || lockout),
		.limit(TW'(WAKE_CYCLES)),
		.done(wakeDone)
	);

	always_ff @(posedge core_clk)
	begin
		if (rst || lockout)
			powerState <= HBC_PWR_ACTIVE;
		else
		begin
			case (powerState)
				HBC_PWR_ACTIVE:
					if (sleepDone)
						powerState <= HBC_PWR_ASLEEP;
				HBC_PWR_ASLEEP:
					if (wakeDone)
						powerState <= HBC_PWR_ACTIVE;
				default:
					powerState <= HBC_PWR_ACTIVE;
			endcase
		end
	end

	// per-half deglitch; a disabled half holds its timer cleared
	genvar h;
	generate
		for (h = 0; h < 2; h++)
		begin : g_half
			hbc_timer #(
				.W(TW)
			) u_ocTimer (
				.core_clk(core_clk),
				.rst(rst),
				.clear(!ocRaw[h] || ocOff[h] || lockout),
				.limit(TW'(OC_CYCLES)),
				.done(trip[h])
			);
		end
	endgenerate

	assign retryRunning = |ocOff;

	// one timer for both halves; any new trip restarts it
	hbc_timer #(
		.W(TW)
	) u_retryTimer (
		.core_clk(core_clk),
		.rst(rst),
		.clear((|trip) || !retryRunning),
		.limit(TW'(RETRY_CYCLES)),
		.done(retryDone)
	);

	// a trip in the expiry cycle wins and starts a fresh interval
	always_comb
	begin
		next_ocOff = ocOff;
		if (retryDone)
			next_ocOff = 2'h0;
		if (|trip)
		begin
			if (iface != HBC_IF_HALF)
				next_ocOff = 2'h3;
			else if (retryRunning || (&trip))
				next_ocOff = 2'h3;
			else
				next_ocOff = ocOff | trip;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || lockout)
			ocOff <= `HBC_OC_OFF_RESET;
		else
			ocOff <= next_ocOff;
	end

	assign driveGate = !lockout && !hot && powerState == HBC_PWR_ACTIVE;

	always_comb
	begin
		legA = HBC_LEG_OFF;
		legB = HBC_LEG_OFF;
		case (iface)
			HBC_IF_DIRECT:
			begin
				case ({inA, inB})
					2'h1:
					begin
						legA = HBC_LEG_LOW;
						legB = HBC_LEG_HIGH;
					end
					2'h2:
					begin
						legA = HBC_LEG_HIGH;
						legB = HBC_LEG_LOW;
					end
					2'h3:
					begin
						legA = HBC_LEG_LOW;
						legB = HBC_LEG_LOW;
					end
					default:
					begin
						legA = HBC_LEG_OFF;
						legB = HBC_LEG_OFF;
					end
				endcase
			end
			HBC_IF_PHASE:
			begin
				if (!inB)
				begin
					legA = HBC_LEG_LOW;
					legB = HBC_LEG_LOW;
				end
				else
				begin
					legA = inA ? HBC_LEG_HIGH : HBC_LEG_LOW;
					legB = inA ? HBC_LEG_LOW : HBC_LEG_HIGH;
				end
			end
			HBC_IF_HALF:
			begin
				legA = inA ? HBC_LEG_HIGH : HBC_LEG_LOW;
				legB = inB ? HBC_LEG_HIGH : HBC_LEG_LOW;
			end
			default:
			begin
				legA = HBC_LEG_OFF;
				legB = HBC_LEG_OFF;
			end
		endcase
	end

	// after retry the legs simply follow the pins again
	assign next_legA = (driveGate && !ocOff[0]) ? legA : HBC_LEG_OFF;
	assign next_legB = (driveGate && !ocOff[1]) ? legB : HBC_LEG_OFF;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			highSideA <= 1'b0;
			lowSideA <= 1'b0;
			highSideB <= 1'b0;
			lowSideB <= 1'b0;
		end
		else
		begin
			highSideA <= next_legA == HBC_LEG_HIGH;
			lowSideA <= next_legA == HBC_LEG_LOW;
			highSideB <= next_legB == HBC_LEG_HIGH;
			lowSideB <= next_legB == HBC_LEG_LOW;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			chargePumpEnable <= 1'b0;
			lowPowerSleep <= 1'b0;
			lockoutActive <= 1'b0;
			thermalActive <= 1'b0;
			overcurrentOffA <= 1'b0;
			overcurrentOffB <= 1'b0;
			activeInterface <= HBC_IF_DIRECT;
		end
		else
		begin
			chargePumpEnable <= !lockout && powerState == HBC_PWR_ACTIVE;
			lowPowerSleep <= powerState == HBC_PWR_ASLEEP;
			lockoutActive <= lockout;
			thermalActive <= hot;
			overcurrentOffA <= ocOff[0];
			overcurrentOffB <= ocOff[1];
			activeInterface <= iface;
		end
	end

	lockout_off_a: assert property (@(posedge core_clk) disable iff (rst)
		lockout |=> !highSideA && !lowSideA && !highSideB && !lowSideB && !chargePumpEnable)
		else $error("switches or pump active during lockout");

	single_direct_a: assert property (@(posedge core_clk) disable iff (rst)
		!isSplit |-> iface == HBC_IF_DIRECT)
		else $error("single supply variant left direct control");

	direct_fwd_a: assert property (@(posedge core_clk) disable iff (rst)
		(iface == HBC_IF_DIRECT && driveGate && ocOff == 2'h0 && inA && !inB)
		|=> highSideA && !lowSideA && lowSideB && !highSideB)
		else $error("direct forward decode wrong");

	phase_brake_a: assert property (@(posedge core_clk) disable iff (rst)
		(iface == HBC_IF_PHASE && driveGate && ocOff == 2'h0 && !inB)
		|=> lowSideA && lowSideB && !highSideA && !highSideB)
		else $error("gate low did not brake");

	phase_dir_a: assert property (@(posedge core_clk) disable iff (rst)
		(iface == HBC_IF_PHASE && driveGate && ocOff == 2'h0 && inB && !inA)
		|=> lowSideA && highSideB)
		else $error("direction zero polarity wrong");

	half_follow_a: assert property (@(posedge core_clk) disable iff (rst)
		(iface == HBC_IF_HALF && driveGate && !ocOff[1])
		|=> highSideB == $past(inB) && lowSideB == !$past(inB))
		else $error("half bridge b does not follow its input");

	thermal_off_a: assert property (@(posedge core_clk) disable iff (rst)
		hot |=> !highSideA && !lowSideA && !highSideB && !lowSideB)
		else $error("switches active while overheated");

	retry_restart_a: assert property (@(posedge core_clk) disable iff (rst || lockout)
		((|trip) && retryRunning) |=> ocOff == 2'h3 ##1 !retryDone)
		else $error("second trip did not restart both halves");

	sleep_enter_a: assert property (@(posedge core_clk) disable iff (rst || lockout)
		(powerState == HBC_PWR_ACTIVE && sleepDone)
		|=> powerState == HBC_PWR_ASLEEP ##1 lowPowerSleep && !highSideA && !lowSideA)
		else $error("idle interval did not enter sleep");

	full_trip_a: assert property (@(posedge core_clk) disable iff (rst || lockout)
		(iface != HBC_IF_HALF && (|trip)) |=> ocOff == 2'h3)
		else $error("overcurrent outside half mode kept one half on");
endmodule

// *** tb/hbc_mcu_model.sv ***
// microcontroller pin model driving the bridge logic inputs
module hbc_mcu_model
(
	input wire logic core_clk,
	input wire logic [1:0] wantMode,
	input wire logic wantA,
	input wire logic wantB,
	input wire logic sleepReq,
	output logic modeLevel,
	output logic modeFloating,
	output logic driveInputA,
	output logic driveInputB
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		modeLevel = 1'h0;
		modeFloating = 1'h0;
		driveInputA = 1'h0;
		driveInputB = 1'h0;
	end
	always @(negedge core_clk)
	begin
		if (sleepReq)
		begin
			// the select pin must be driven low, a floating select never sleeps
			modeFloating <= 1'h0;
			modeLevel <= 1'h0;
			driveInputA <= 1'h0;
			driveInputB <= 1'h0;
		end
		else
		begin
			modeFloating <= (wantMode == 2'h2);
			// a released select line has no stable level, so it toggles
			modeLevel <= (wantMode == 2'h2) ? ~modeLevel : wantMode[0];
			driveInputA <= wantA;
			driveInputB <= wantB;
		end
	end
endmodule

// *** tb/tb_hbc_control_logic.sv ***
// self-checking bench for the h-bridge control logic
module tb_hbc_control_logic;
	timeunit 1ns;
	timeprecision 1ps;
	import hbc_pkg::*;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic splitVariant = 1'h1;
	logic logicSupplyLow = 1'h0;
	logic motorSupplyLow = 1'h0;
	logic overcurrentA = 1'h0;
	logic overcurrentB = 1'h0;
	logic thermalCutoff = 1'h0;
	logic [1:0] wantMode = 2'h0;
	logic wantA = 1'h0;
	logic wantB = 1'h0;
	logic sleepReq = 1'h0;
	logic modeLevel, modeFloating, driveInputA, driveInputB;
	logic highSideA, lowSideA, highSideB, lowSideB, chargePumpEnable, lowPowerSleep;
	logic lockoutActive, overcurrentOffA, overcurrentOffB, thermalActive;
	hbc_iface_t activeInterface;
	int failCount = 0;
	int checks = 0;
	logic [3:0] dirTable [4] = '{4'h0, 4'h6, 4'h9, 4'h5};
	wire [3:0] sw = {highSideA, lowSideA, highSideB, lowSideB};

	hbc_mcu_model mcu (.core_clk(core_clk), .wantMode(wantMode), .wantA(wantA), .wantB(wantB),
		.sleepReq(sleepReq), .modeLevel(modeLevel), .modeFloating(modeFloating),
		.driveInputA(driveInputA), .driveInputB(driveInputB));

	// short timers keep the run brief; expectations below assume these values
	hbc_control_logic #(.RETRY_CYCLES(40), .SLEEP_CYCLES(30), .WAKE_CYCLES(16), .OC_CYCLES(5)) uut (
		.core_clk(core_clk), .rst(rst), .splitVariant(splitVariant), .modeLevel(modeLevel),
		.modeFloating(modeFloating), .driveInputA(driveInputA), .driveInputB(driveInputB),
		.logicSupplyLow(logicSupplyLow), .motorSupplyLow(motorSupplyLow), .overcurrentA(overcurrentA),
		.overcurrentB(overcurrentB), .thermalCutoff(thermalCutoff), .highSideA(highSideA),
		.lowSideA(lowSideA), .highSideB(highSideB), .lowSideB(lowSideB),
		.chargePumpEnable(chargePumpEnable), .lowPowerSleep(lowPowerSleep),
		.lockoutActive(lockoutActive), .overcurrentOffA(overcurrentOffA),
		.overcurrentOffB(overcurrentOffB), .thermalActive(thermalActive),
		.activeInterface(activeInterface));

	initial
	begin
		forever #25 core_clk = ~core_clk;
	end

	task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failCount++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic pins(input logic [1:0] m, input logic a, input logic b, input int n);
		wantMode = m;
		wantA = a;
		wantB = b;
		step(n);
	endtask

	task automatic report_and_stop;
		$display("checks %0d failCount %0d", checks, failCount);
		if (failCount == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic testDirect;
		for (int i = 0; i < 4; i++)
		begin
			pins(2'h0, i[1], i[0], 25);
			check("direct", sw, dirTable[i]);
		end
		check("directIface", {2'h0, activeInterface}, {2'h0, HBC_IF_DIRECT});
	endtask

	task automatic testPhase;
		for (int i = 3; i > 0; i--)
		begin
			pins(2'h1, i[0], i[1], 25);
			check("phase", sw, i[1] ? {i[0], ~i[0], ~i[0], i[0]} : 4'h5);
		end
		check("phaseIface", {2'h0, activeInterface}, {2'h0, HBC_IF_PHASE});
		pins(2'h1, 1'h0, 1'h0, 20);
		check("phaseSleep", {lowPowerSleep, sw[2:0]}, 4'h8);
	endtask

	task automatic testHalf;
		pins(2'h1, 1'h0, 1'h1, 25);
		for (int i = 0; i < 4; i++)
		begin
			pins(2'h2, i[1], i[0], 10);
			check("half", sw, {i[1], ~i[1], i[0], ~i[0]});
		end
		check("halfIface", {2'h0, activeInterface}, {2'h0, HBC_IF_HALF});
		sleepReq = 1'h1;
		step(40);
		check("halfSleep", {lowPowerSleep, sw[2:0]}, 4'h8);
		pins(2'h0, 1'h0, 1'h0, 0);
		sleepReq = 1'h0;
	endtask

	task automatic testSleep;
		// a broken wake hold must start over
		pins(2'h0, 1'h1, 1'h0, 8);
		pins(2'h0, 1'h0, 1'h0, 2);
		pins(2'h0, 1'h1, 1'h0, 12);
		check("wakeBroken", {lowPowerSleep, sw[2:0]}, 4'h8);
		step(10);
		check("woken", {lowPowerSleep, sw[2:0]}, 4'h1);
		pins(2'h0, 1'h0, 1'h0, 20);
		pins(2'h0, 1'h1, 1'h0, 2);
		pins(2'h0, 1'h0, 1'h0, 20);
		check("sleepRestart", {lowPowerSleep, sw[2:0]}, 4'h0);
		step(15);
		check("coastSleep", {3'h0, lowPowerSleep}, 4'h1);
	endtask

	task automatic testLockout;
		pins(2'h0, 1'h1, 1'h0, 25);
		motorSupplyLow = 1'h1;
		step(6);
		check("motorLowSplit", sw, 4'h9);
		logicSupplyLow = 1'h1;
		step(6);
		check("lockSw", sw, 4'h0);
		check("lockFlags", {2'h0, lockoutActive, chargePumpEnable}, 4'h2);
		logicSupplyLow = 1'h0;
		step(6);
		check("lockRelease", sw, 4'h9);
		motorSupplyLow = 1'h0;
		splitVariant = 1'h0;
		logicSupplyLow = 1'h1;
		pins(2'h1, 1'h1, 1'h0, 8);
		check("singleDirect", sw, 4'h9);
		motorSupplyLow = 1'h1;
		step(6);
		check("singleLock", {lockoutActive, sw[2:0]}, 4'h8);
		motorSupplyLow = 1'h0;
		logicSupplyLow = 1'h0;
		splitVariant = 1'h1;
		pins(2'h0, 1'h1, 1'h0, 8);
	endtask

	task automatic testOvercurrent;
		overcurrentA = 1'h1;
		step(3);
		overcurrentA = 1'h0;
		step(6);
		check("ocGlitch", sw, 4'h9);
		overcurrentA = 1'h1;
		step(8);
		overcurrentA = 1'h0;
		step(2);
		check("ocTrip", {overcurrentOffA, overcurrentOffB, sw[1:0]}, 4'hC);
		check("ocTripSw", sw, 4'h0);
		step(25);
		check("ocRetry", sw, 4'h0);
		step(20);
		check("ocResume", sw, 4'h9);
		overcurrentA = 1'h1;
		step(60);
		check("ocRepeat", {3'h0, overcurrentOffA}, 4'h1);
		overcurrentA = 1'h0;
		step(60);
	endtask

	task automatic testHalfOc;
		pins(2'h2, 1'h1, 1'h1, 10);
		overcurrentB = 1'h1;
		step(8);
		overcurrentB = 1'h0;
		step(4);
		check("halfOcOne", sw, 4'h8);
		check("halfOcFlags", {2'h0, overcurrentOffA, overcurrentOffB}, 4'h1);
		step(8);
		overcurrentA = 1'h1;
		step(8);
		overcurrentA = 1'h0;
		step(30);
		check("sharedRetry", sw, 4'h0);
		step(22);
		check("sharedResume", sw, 4'hA);
	endtask

	task automatic testThermal;
		thermalCutoff = 1'h1;
		step(6);
		check("thermalOff", {thermalActive, sw[2:0]}, 4'h8);
		thermalCutoff = 1'h0;
		step(6);
		check("thermalResume", sw, 4'hA);
	endtask

	initial
	begin
		step(4);
		rst = 1'h0;
		testDirect;
		testPhase;
		testHalf;
		testSleep;
		testLockout;
		testOvercurrent;
		testHalfOc;
		testThermal;
		report_and_stop;
	end

	initial
	begin
		step(20000);
		failCount++;
		report_and_stop;
	end
endmodule
